// [sdc_pkg.sv]
// Shared constants, types and helpers for the SDRAM command link.
// Assumes both ends run on the one system clock pclk.
`default_nettype none
package sdc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int NBANK = 4;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int AP_BIT = 10;
  localparam int BYTE_W = 8;
  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] MR_CL3 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  // ----------------------------------------------------------------
  // Command codes as {select_n, row_n, col_n, write_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // ----------------------------------------------------------------
  // Controller register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam int CTRL_CKE = 0;
  localparam int CTRL_CL3 = 1;
  localparam int CTRL_REFEN = 2;
  localparam int ADDR_BANK_LSB = 13;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RDV = 1;
  localparam int STAT_REFP = 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] CAP_DLY_CL2 = 3'h3;
  localparam logic [2:0] CAP_DLY_CL3 = 3'h4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int REF_WINDOW_MS = 64;
  localparam int REF_ROWS = 8192;
  localparam int REF_INT_CYC =
    REF_WINDOW_MS * 1000000 / REF_ROWS / CLK_PERIOD_NS;
  localparam logic [9:0] REF_LAST = 10'(REF_INT_CYC - 1);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SDC_RUN, SDC_PDN, SDC_SREF} sdc_pwr_e;
  typedef enum logic [1:0] {SDC_IDLE, SDC_WAIT, SDC_REFR} sdc_cst_e;

  // Burst length in words for a mode-register length code.
  function automatic logic [9:0] sdc_burst_len(input logic [2:0] bl);
    case (bl)
      3'h0: sdc_burst_len = 10'h001;
      3'h1: sdc_burst_len = 10'h002;
      3'h2: sdc_burst_len = 10'h004;
      3'h3: sdc_burst_len = 10'h008;
      BL_FULL: sdc_burst_len = 10'h200;
      default: sdc_burst_len = 10'h001;
    endcase
  endfunction

  // Column of word cnt within a burst; only the low bits wrap.
  function automatic logic [8:0] sdc_burst_col(input logic [8:0] st,
      input logic [8:0] cnt, input logic [2:0] bl, input logic ilv);
    logic [8:0] m;
    logic [8:0] low;
    m = 9'(sdc_burst_len(bl) - 10'h001);
    low = (ilv && bl != BL_FULL) ? (st ^ cnt) : 9'(st + cnt);
    sdc_burst_col = (st & ~m) | (low & m);
  endfunction
endpackage
`default_nettype wire

// [sdc_if.sv]
// Pin bundle between the memory controller and the SDRAM device.
// Assumes both parties share pclk; the data lines are resolved here.
`timescale 1ns/1ps
`default_nettype none
interface sdc_if;
  import sdc_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] bank_select;
  logic [ADDR_W-1:0] addr_bus;
  logic [MASK_W-1:0] byte_mask;
  logic [DATA_W-1:0] host_dq_o;
  logic host_dq_oe;
  logic [DATA_W-1:0] mem_dq_o;
  logic [MASK_W-1:0] mem_dq_oe;
  logic [DATA_W-1:0] data_lines;

  // Per-byte wire level: the device wins where it drives, else host.
  always_comb begin
    for (int b = 0; b < MASK_W; b++) begin
      if (mem_dq_oe[b])
        data_lines[b*BYTE_W +: BYTE_W] = mem_dq_o[b*BYTE_W +: BYTE_W];
      else if (host_dq_oe)
        data_lines[b*BYTE_W +: BYTE_W] = host_dq_o[b*BYTE_W +: BYTE_W];
      else
        data_lines[b*BYTE_W +: BYTE_W] = '0;
    end
  end

  modport host (output cke, cs_n, ras_n, cas_n, we_n, bank_select,
    addr_bus, byte_mask, host_dq_o, host_dq_oe, input data_lines);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_select,
    addr_bus, byte_mask, data_lines, output mem_dq_o, mem_dq_oe);
endinterface
`default_nettype wire

// [sdc_mem.sv]
// Four-bank synchronous DRAM device end of the command link.
// Assumes a controller on the same pclk; presetn only stands for the
// power-up state, since the device itself has no reset pin.
//
// Summary of operation
// - All inputs sampled on rising clock edge.
// - Each edge advances burst column and outputs.
// - Low clock-gate freezes outputs and burst next cycle.
// - Clock-gate low with banks idle enters sleep.
// - Sleep ignores every input except clock-gate.
// - Bank select picks target bank of command.
// - Banks hold 8192 rows of 512 words.
// - Column access: bit 10 auto-precharge, nine column bits.
// - Precharge: bit 10 high closes all banks.
// - Mode set takes settings from address bus.
// - Commands ignored while chip select high.
// - Row strobe alone: activate or close bank.
// - Column strobe alone starts a column access.
// - Byte masks act per cycle, float data bytes.
// - Masked bytes are not stored on writes.
// - Read masks blank output byte two clocks later.
// - Mask bit n covers data byte n.
// - Read latency two or three clocks.
// - Burst length 1, 2, 4, 8 or page.
// - Burst order interleaved or linear.
// - 32-bit data moves on rising edges.
// - Write-enable high reads, low writes, open row.
// - First read word after latency, then each edge.
`timescale 1ns/1ps
`default_nettype none
module sdc_mem (
  input wire logic pclk,
  input wire logic presetn,
  sdc_if.mem bus
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cke_q;
    sdc_pwr_e pwr;
    logic [NBANK-1:0] act;
    logic [NBANK-1:0][ROW_W-1:0] row;
    logic [2:0] bl;
    logic ilv;
    logic cl3;
    logic bact;
    logic bwr;
    logic bap;
    logic [BANK_W-1:0] bbank;
    logic [COL_W-1:0] bstart;
    logic [COL_W-1:0] bcnt;
    logic [1:0] rv;
    logic [1:0][DATA_W-1:0] rd;
    logic [MASK_W-1:0] mq;
    logic [DATA_W-1:0] dq;
    logic [MASK_W-1:0] oe;
  } sdc_mem_s;

  sdc_mem_s s_r;
  sdc_mem_s s_nxt;

  // The cell array is far too large for the state struct.
  logic [DATA_W-1:0] store_r [0:(1<<MEM_AW)-1];
  logic wr_en;
  logic [MEM_AW-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [MASK_W-1:0] wr_keep;

  assign bus.mem_dq_o = s_r.dq;
  assign bus.mem_dq_oe = s_r.oe;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Commands count only when the clock gate was high the edge before,
  // which is what makes a low gate suspend from the next cycle on.
  always_comb begin
    logic [3:0] code;
    logic en;
    logic go;
    logic wr;
    logic ap;
    logic last;
    logic kill;
    logic [BANK_W-1:0] bk;
    logic [COL_W-1:0] st;
    logic [COL_W-1:0] cnt;
    logic [COL_W-1:0] col;
    logic [MEM_AW-1:0] idx;
    code = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    en = s_r.cke_q && (s_r.pwr == SDC_RUN);
    go = 1'b0;
    wr = 1'b0;
    ap = 1'b0;
    last = 1'b0;
    kill = 1'b0;
    bk = bus.bank_select;
    st = bus.addr_bus[COL_W-1:0];
    cnt = '0;
    col = '0;
    idx = '0;
    wr_en = 1'b0;
    wr_idx = '0;
    wr_data = '0;
    wr_keep = '0;
    s_nxt = s_r;
    s_nxt.cke_q = bus.cke;
    if (s_r.pwr != SDC_RUN) begin
      // Buffers are off: only the gate is watched, as a plain level.
      if (bus.cke)
        s_nxt.pwr = SDC_RUN;
    end else if (en) begin
      // Masks live for one cycle; the copy only delays them.
      s_nxt.mq = bus.byte_mask;
      // Read pipeline: stage 0 holds the word fetched this edge.
      s_nxt.rv = {s_r.rv[0], 1'b0};
      s_nxt.rd[1] = s_r.rd[0];
      // Latency 3 takes one stage more; the mask copy lands the
      // blanking two edges after it was sampled.
      s_nxt.dq = s_r.cl3 ? s_r.rd[1] : s_r.rd[0];
      s_nxt.oe = {MASK_W{s_r.cl3 ? s_r.rv[1] : s_r.rv[0]}}
        & ~s_r.mq;
      // A deselected cycle never matches any code below.
      case (code)
        CMD_ACT: begin
          if (!s_r.act[bk]) begin
            s_nxt.act[bk] = 1'b1;
            s_nxt.row[bk] = bus.addr_bus;
          end
        end
        CMD_PRE: begin
          kill = 1'b1;
          if (bus.addr_bus[AP_BIT])
            s_nxt.act = '0;
          else
            s_nxt.act[bk] = 1'b0;
        end
        CMD_RD, CMD_WR: begin
          // A column access needs an open row in its bank.
          if (s_r.act[bk]) begin
            go = 1'b1;
            wr = (code == CMD_WR);
            ap = bus.addr_bus[AP_BIT];
          end
        end
        CMD_BST: kill = 1'b1;
        CMD_MRS: begin
          if (s_r.act == '0 && !s_r.bact) begin
            s_nxt.bl = bus.addr_bus[MR_BL_LSB +: 3];
            s_nxt.ilv = bus.addr_bus[MR_BT_BIT];
            s_nxt.cl3 =
              (bus.addr_bus[MR_CL_LSB +: 3] == MR_CL3);
          end
        end
        default: ;
      endcase
      if (kill)
        s_nxt.bact = 1'b0;
      // Without a new access the running burst takes its next word.
      if (!go && !kill && s_r.bact) begin
        go = 1'b1;
        wr = s_r.bwr;
        ap = s_r.bap;
        bk = s_r.bbank;
        st = s_r.bstart;
        cnt = s_r.bcnt;
      end
      if (go) begin
        col = sdc_burst_col(st, cnt, s_r.bl, s_r.ilv);
        idx = {bk, s_r.row[bk], col};
        if (wr) begin
          wr_en = 1'b1;
          wr_idx = idx;
          wr_data = bus.data_lines;
          wr_keep = ~bus.byte_mask;
        end else begin
          s_nxt.rv[0] = 1'b1;
          s_nxt.rd[0] = store_r[idx];
        end
        // A page burst wraps round the row until it is cut off.
        last = (s_r.bl != BL_FULL) &&
          (10'(cnt) + 10'h001 == sdc_burst_len(s_r.bl));
        s_nxt.bact = !last;
        s_nxt.bcnt = cnt + 9'h001;
        s_nxt.bwr = wr;
        s_nxt.bap = ap;
        s_nxt.bbank = bk;
        s_nxt.bstart = st;
        if (last && ap)
          s_nxt.act[bk] = 1'b0;
      end
      // A gate falling with everything idle enters a sleep mode.
      if (!bus.cke && s_r.act == '0 && !s_r.bact) begin
        s_nxt.pwr = (code == CMD_REF) ? SDC_SREF : SDC_PDN;
        s_nxt.oe = '0;
      end
    end
    // With the gate low and a bank open, everything above is skipped
    // and all state but the gate copy cke_q, outputs included, stays frozen.
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Power-up state: all banks idle, no burst, data lines released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Byte-wise cell writes; masked bytes keep their old contents.
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      for (int b = 0; b < MASK_W; b++) begin
        if (wr_keep[b])
          store_r[wr_idx][b*BYTE_W +: BYTE_W] <=
            wr_data[b*BYTE_W +: BYTE_W];
      end
    end
  end
endmodule // sdc_mem
`default_nettype wire

// [sdc_ctrl.sv]
// Memory controller end of the SDRAM command link, run over APB.
// Assumes the device shares pclk; software issues one command per
// CMD register write and polls STATUS.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sdc_if.host bus
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cke;
    logic cl3;
    logic refen;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic rdv;
    sdc_cst_e st;
    logic [2:0] cnt;
    logic [9:0] refcnt;
    logic refp;
    logic [3:0] cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] ab;
    logic [DATA_W-1:0] dqo;
    logic dqoe;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } sdc_ctrl_s;

  sdc_ctrl_s s_r;
  sdc_ctrl_s s_nxt;

  // Every pin comes straight from the state flops.
  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = s_r.cmd;
  assign bus.cke = s_r.cke;
  assign bus.bank_select = s_r.ba;
  assign bus.addr_bus = s_r.ab;
  assign bus.byte_mask = s_r.mask;
  assign bus.host_dq_o = s_r.dqo;
  assign bus.host_dq_oe = s_r.dqoe;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Pins change only right after an edge, so the device always sees
  // them stable at the next one.
  always_comb begin
    logic setup;
    logic acc;
    logic issue;
    setup = psel && !penable;
    acc = psel && penable && s_r.pready;
    issue = acc && pwrite && (paddr == REG_CMD) && (s_r.st == SDC_IDLE);
    s_nxt = s_r;
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.cmd = CMD_NOP;
    s_nxt.dqoe = 1'b0;
    // Read data and error are fixed in the setup cycle.
    if (setup) begin
      s_nxt.prdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL: begin
          s_nxt.prdata[CTRL_CKE] = s_r.cke;
          s_nxt.prdata[CTRL_CL3] = s_r.cl3;
          s_nxt.prdata[CTRL_REFEN] = s_r.refen;
        end
        REG_ADDR: s_nxt.prdata[ADDR_BANK_LSB+BANK_W-1:0] =
          {s_r.bank, s_r.addr};
        REG_WDATA: s_nxt.prdata = s_r.wdata;
        REG_MASK: s_nxt.prdata[MASK_W-1:0] = s_r.mask;
        REG_CMD: ;
        REG_RDATA: s_nxt.prdata = s_r.rdata;
        REG_STAT: begin
          s_nxt.prdata[STAT_BUSY] = (s_r.st != SDC_IDLE);
          s_nxt.prdata[STAT_RDV] = s_r.rdv;
          s_nxt.prdata[STAT_REFP] = s_r.refp;
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // Register writes take effect at the completing edge.
    if (acc && pwrite) begin
      case (paddr)
        REG_CTRL: begin
          s_nxt.cke = pwdata[CTRL_CKE];
          s_nxt.cl3 = pwdata[CTRL_CL3];
          s_nxt.refen = pwdata[CTRL_REFEN];
        end
        REG_ADDR: {s_nxt.bank, s_nxt.addr} =
          pwdata[ADDR_BANK_LSB+BANK_W-1:0];
        REG_WDATA: s_nxt.wdata = pwdata;
        REG_MASK: s_nxt.mask = pwdata[MASK_W-1:0];
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == REG_RDATA)
      s_nxt.rdv = 1'b0;
    // Refresh interval timer; a pending tick waits for an idle slot.
    if (s_r.refcnt == REF_LAST) begin
      s_nxt.refcnt = '0;
      s_nxt.refp = s_r.refen;
    end else begin
      s_nxt.refcnt = s_r.refcnt + 10'h001;
    end
    case (s_r.st)
      SDC_IDLE: begin
        if (issue) begin
          // Bank and address ride alongside the command code.
          s_nxt.cmd = pwdata[3:0];
          s_nxt.ba = s_r.bank;
          s_nxt.ab = s_r.addr;
          s_nxt.dqo = s_r.wdata;
          s_nxt.dqoe = (pwdata[3:0] == CMD_WR);
          if (pwdata[3:0] == CMD_RD) begin
            s_nxt.st = SDC_WAIT;
            s_nxt.cnt = s_r.cl3 ? CAP_DLY_CL3 : CAP_DLY_CL2;
          end
        end else if (s_r.refp && s_r.refen) begin
          // Rows are closed first, so refresh always finds idle banks.
          s_nxt.cmd = CMD_PRE;
          s_nxt.ab = '0;
          s_nxt.ab[AP_BIT] = 1'b1;
          s_nxt.st = SDC_REFR;
        end
      end
      SDC_WAIT: begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        if (s_r.cnt == 3'h1) begin
          s_nxt.rdata = bus.data_lines;
          s_nxt.rdv = 1'b1; // Set wins over the read clear.
          s_nxt.st = SDC_IDLE;
        end
      end
      SDC_REFR: begin
        s_nxt.cmd = CMD_REF;
        s_nxt.refp = 1'b0;
        s_nxt.st = SDC_IDLE;
      end
      default: s_nxt.st = SDC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves the link deselected with the clock gate low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.cmd <= 4'hF;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sdc_ctrl
`default_nettype wire

// [sdc_properties.sv]
// Pin-level checks of the SDRAM command link.
// Assumes it sits beside the sdc_if joining controller and device.
`timescale 1ns/1ps
`default_nettype none
module sdc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdc_pkg::BANK_W-1:0] bank_select,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr_bus,
  input wire logic [sdc_pkg::MASK_W-1:0] byte_mask,
  input wire logic host_dq_oe,
  input wire logic [sdc_pkg::MASK_W-1:0] mem_dq_oe
);
  import sdc_pkg::*;
  typedef struct packed {
    logic cke_q;
    logic cl3;
    logic [2:0] bl;
    logic [NBANK-1:0] open;
  } sdc_chk_s;
  sdc_chk_s chk_r;
  sdc_chk_s chk_nxt;
  logic [3:0] cmd;
  logic rd_ok;
  // ----------------------------------------------------------------
  // Shadow of the device state
  // ----------------------------------------------------------------
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign rd_ok = chk_r.cke_q && cmd == CMD_RD &&
    chk_r.open[bank_select] && byte_mask == '0;
  // Auto-precharge closes the bank at once here; besides making the read
  // checks skip a case, it can let the shadow take a mode set that the device refuses.
  always_comb begin
    chk_nxt = chk_r;
    chk_nxt.cke_q = cke;
    if (chk_r.cke_q) begin
      case (cmd)
        CMD_ACT: chk_nxt.open[bank_select] = 1'h1;
        CMD_PRE: begin
          if (addr_bus[AP_BIT])
            chk_nxt.open = '0;
          else
            chk_nxt.open[bank_select] = 1'h0;
        end
        CMD_RD, CMD_WR: begin
          if (addr_bus[AP_BIT])
            chk_nxt.open[bank_select] = 1'h0;
        end
        CMD_MRS: begin
          if (chk_r.open == '0 && mem_dq_oe == '0) begin
            chk_nxt.cl3 = addr_bus[MR_CL_LSB +: 3] == MR_CL3;
            chk_nxt.bl = addr_bus[MR_BL_LSB +: 3];
          end
        end
        default: ;
      endcase
    end
  end
  // Shadow register; power-up state is mode zero with all banks idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      chk_r <= '0;
    else
      chk_r <= chk_nxt;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd2;
    (rd_ok && !chk_r.cl3 && cke) ##1 cke;
  endsequence
  sequence s_rd3;
    (rd_ok && chk_r.cl3 && cke) ##1 (cke && byte_mask == '0) ##1 cke;
  endsequence
  sequence s_rd1;
    (rd_ok && !chk_r.cl3 && chk_r.bl == 3'h0 && cke) ##1 cke[*3];
  endsequence
  property p_cmd_pulse;
    (!cs_n && cmd != CMD_NOP && cmd != CMD_PRE) |=> cmd == CMD_NOP;
  endproperty
  property p_host_drive;
    host_dq_oe |-> cmd == CMD_WR;
  endproperty
  property p_wr_pulse;
    cmd == CMD_WR |-> host_dq_oe ##1 !host_dq_oe;
  endproperty
  property p_mask_blank;
    (cke && $past(cke) && $past(cke, 2)) |->
      (mem_dq_oe & $past(byte_mask, 2)) == '0;
  endproperty
  property p_rd_cl2;
    s_rd2 |=> mem_dq_oe == 4'hF;
  endproperty
  property p_rd_cl3;
    s_rd3 |=> mem_dq_oe == 4'hF;
  endproperty
  property p_rd_end;
    s_rd1 |-> mem_dq_oe == '0;
  endproperty
  property p_freeze;
    !cke |-> ##2 $stable(mem_dq_oe);
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command held longer than one cycle");
  a_host_drive: assert property (p_host_drive)
    else $error("host drives data outside a write");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write data not driven for one cycle");
  a_mask_blank: assert property (p_mask_blank)
    else $error("masked read byte driven");
  a_rd_cl2: assert property (p_rd_cl2)
    else $error("read word late at latency two");
  a_rd_cl3: assert property (p_rd_cl3)
    else $error("read word late at latency three");
  a_rd_end: assert property (p_rd_end)
    else $error("single word burst did not end");
  a_freeze: assert property (p_freeze)
    else $error("device output moved while clock gated");
endmodule // sdc_properties
`default_nettype wire

// [sdc_test.sv]
// Self-checking bench: APB drives the controller, the device answers.
// Assumes the package, sdc_if and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  err_count++; $display("CHECK FAILED at %0t: got %h expected %h", \
  $time, got, exp); end end
module sdc_test;
  import sdc_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rq;
  logic re;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  sdc_if sdc_if_inst ();
  sdc_ctrl sdc_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(sdc_if_inst));
  sdc_mem sdc_mem_inst (.pclk(pclk), .presetn(presetn), .bus(sdc_if_inst));
  sdc_properties sdc_properties_inst (.pclk(pclk), .presetn(presetn),
    .cke(sdc_if_inst.cke), .cs_n(sdc_if_inst.cs_n),
    .ras_n(sdc_if_inst.ras_n), .cas_n(sdc_if_inst.cas_n),
    .we_n(sdc_if_inst.we_n), .bank_select(sdc_if_inst.bank_select),
    .addr_bus(sdc_if_inst.addr_bus), .byte_mask(sdc_if_inst.byte_mask),
    .host_dq_oe(sdc_if_inst.host_dq_oe), .mem_dq_oe(sdc_if_inst.mem_dq_oe));
  // ----------------------------------------------------------------
  // Clock, timeout and closing report
  // ----------------------------------------------------------------
  always #4 pclk = ~pclk;
  // The whole run needs under two thousand cycles; this cuts a hang short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------------
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    apb(1'h1, a, d, rq, re);
  endtask
  task automatic rreg(logic [7:0] a);
    apb(1'h0, a, '0, rq, re);
  endtask
  // A command written while busy is dropped, so wait for busy to clear.
  task automatic cmd(logic [3:0] c, logic [1:0] bk, logic [12:0] ad);
    wreg(REG_ADDR, {17'h0, bk, ad});
    wreg(REG_CMD, {28'h0, c});
    for (int k = 0; k < 40; k++) begin
      rreg(REG_STAT);
      if (rq[STAT_BUSY] === 1'h0) break;
    end
  endtask
  task automatic rd(logic [1:0] bk, logic [8:0] col, logic [31:0] exp);
    cmd(CMD_RD, bk, {4'h0, col});
    for (int k = 0; k < 40 && rq[STAT_RDV] !== 1'h1; k++)
      rreg(REG_STAT);
    rreg(REG_RDATA);
    `CHK(rq, exp)
  endtask
  task automatic wr(logic [1:0] bk, logic [8:0] col, logic [31:0] d,
      logic [3:0] m);
    wreg(REG_MASK, {28'h0, m});
    wreg(REG_WDATA, d);
    cmd(CMD_WR, bk, {4'h0, col});
  endtask
  function automatic logic [31:0] pat(logic [1:0] b, logic [8:0] c);
    return 32'h5A5A_5A5A ^ {8'hC3, 6'h00, b, 7'h00, c};
  endfunction
  function automatic logic [31:0] mrg(logic [1:0] b);
    return (pat(b, 9'h1FF) & 32'hFF00_FF00) | 32'h00FF_00FF;
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_apb();
    apb(1'h0, 8'h1C, '0, rq, re);
    `CHK(re, 1'h1)
    `CHK(rq, 32'h0000_0000)
  endtask
  // Top column of every bank, rows 1FFF down to 1FFC; masked bytes keep old data.
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      cmd(CMD_ACT, 2'(b), 13'h1FFF - 13'(b));
      wr(2'(b), 9'h1FF, pat(2'(b), 9'h1FF), 4'h0);
      wr(2'(b), 9'h1FF, 32'hFFFF_FFFF, 4'hA);
    end
    wreg(REG_MASK, 32'h0000_0000);
    for (int b = 0; b < 4; b++)
      rd(2'(b), 9'h1FF, mrg(2'(b)));
  endtask
  task automatic t_rmask();
    for (int i = 0; i < 4; i++) begin
      wreg(REG_MASK, 32'h0000_0001 << i);
      rd(2'h0, 9'h1FF, mrg(2'h0) & ~(32'h0000_00FF << (8 * i)));
    end
    wreg(REG_MASK, 32'h0000_0000);
  endtask
  // Closed or deselected banks must not return data.
  task automatic t_close();
    cmd(CMD_PRE, 2'h3, 13'h0000);
    rd(2'h3, 9'h1FF, 32'h0000_0000);
    rd(2'h2, 9'h1FF, mrg(2'h2));
    cmd(4'hB, 2'h3, 13'h1FFC);
    rd(2'h3, 9'h1FF, 32'h0000_0000);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    rd(2'h2, 9'h1FF, 32'h0000_0000);
  endtask
  task automatic t_cl3();
    wreg(REG_CTRL, 32'h0000_0003);
    cmd(CMD_MRS, 2'h0, 13'h0030);
    cmd(CMD_ACT, 2'h0, 13'h0000);
    for (int c = 0; c < 4; c++)
      wr(2'h0, 9'(c), pat(2'h0, 9'(c)), 4'h0);
    rd(2'h0, 9'h002, pat(2'h0, 9'h002));
  endtask
  // Four-word bursts from column 1 watched on the data lines.
  task automatic t_burst();
    logic [8:0] c;
    for (int v = 0; v < 2; v++) begin
      cmd(CMD_PRE, 2'h0, 13'h0400);
      wreg(REG_CTRL, 32'h0000_0001);
      cmd(CMD_MRS, 2'h0, {9'h000, 1'(v), 3'h2});
      cmd(CMD_ACT, 2'h0, 13'h0000);
      fork
        cmd(CMD_RD, 2'h0, 13'h0001);
        begin
          for (int k = 0; k < 60 && sdc_if_inst.mem_dq_oe !== 4'hF; k++)
            @(posedge pclk);
          for (int j = 0; j < 4; j++) begin
            c = 9'(v ? 1 ^ j : (1 + j) % 4);
            `CHK(sdc_if_inst.data_lines, pat(2'h0, c))
            @(posedge pclk);
          end
        end
      join
    end
  endtask
  // Refresh closes every row; a sleeping device ignores an activate.
  task automatic t_ref();
    wreg(REG_CTRL, 32'h0000_0005);
    repeat (1000) @(posedge pclk);
    wreg(REG_CTRL, 32'h0000_0000);
    cmd(CMD_ACT, 2'h0, 13'h0000);
    wreg(REG_CTRL, 32'h0000_0001);
    rd(2'h0, 9'h001, 32'h0000_0000);
  endtask
  // Main sequence: reset, clock gate on, then the scenarios.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    wreg(REG_CTRL, 32'h0000_0001);
    t_apb();
    t_banks();
    t_rmask();
    t_close();
    t_cl3();
    t_burst();
    t_ref();
    test_done();
  end
endmodule // sdc_test
`default_nettype wire
